// >>> common/zbsc_defines.vh
// constants for the byte-write / chip-select slice of the burst SRAM
`ifndef ZBSC_DEFINES_VH
`define ZBSC_DEFINES_VH
`define ZBSC_LANES 4
`define ZBSC_LANE_W 9
`define ZBSC_WORD_W 36
`define ZBSC_ADDR_W 17
`define ZBSC_BURST_W 2
`define ZBSC_REG_AW 4
`define ZBSC_REG_LANE_MASK 4'h0
`define ZBSC_REG_STATUS 4'h4
`define ZBSC_REG_WCOUNT 4'h8
`define ZBSC_REG_RCOUNT 4'hC
`define ZBSC_LANE_MASK_RST 4'h0
`define ZBSC_ST_SEL 0
`define ZBSC_ST_P1 1
`define ZBSC_ST_P2 2
`define ZBSC_ST_DRV 3
`define ZBSC_ST_HOLD 4
`define ZBSC_ST_BURST 5
`define ZBSC_CNT_W 16
`define ZBSC_OP_IDLE 2'h0
`define ZBSC_OP_READ 2'h1
`define ZBSC_OP_WRITE 2'h2
`endif

// >>> hdl/zbsc_sram_slice.v
// burst SRAM slice: byte-lane writes, three-way chip select, two-stage pipe
//
// The register offsets and strobed register access were left to the implementer.
`include "zbsc_defines.vh"

// Behaviour
// - one active-low write enable per 9-bit lane, sampled on rising edge
// - lane enables are ignored when read_not_write is sampled high at a load, and on read burst advances
// - enabled lanes store the data sampled two edges after the address
// - load with any select inactive starts a deselect cycle
// - bus floats two cycles after deselect; earlier transfers still finish
// - high select acts like the low selects; all three must be active
// - every synchronous input is sampled and launched on rising edge
// - read_not_write at load picks the access; data moves two cycles on
// - clock_hold_n high freezes the pipe as if the edge never came
module zbsc_sram_slice #(
  parameter ADDR_W = `ZBSC_ADDR_W,
  parameter LANES = `ZBSC_LANES,
  parameter LANE_W = `ZBSC_LANE_W,
  parameter BURST_W = `ZBSC_BURST_W,
  parameter CNT_W = `ZBSC_CNT_W
) (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire clock_hold_n_i,
  input wire chip_select_low_a_i,
  input wire chip_select_low_b_i,
  input wire chip_select_high_i,
  input wire advance_not_load_i,
  input wire read_not_write_i,
  input wire [LANES-1:0] byte_lane_write_n_i,
  input wire [ADDR_W-1:0] addr_i,
  input wire [LANES*LANE_W-1:0] data_i,
  output reg [LANES*LANE_W-1:0] data_o,
  output reg data_oe_o,
  input wire [`ZBSC_REG_AW-1:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o
);

  localparam WORD_W = LANES * LANE_W;
  localparam DEPTH = 1 << ADDR_W;

  // stage 1: control sampled at the load/advance edge
  reg [1:0] p1_op_r;
  reg [ADDR_W-1:0] p1_addr_r;
  reg [LANES-1:0] p1_we_r;
  // stage 2: data moves on the bus during this stage
  reg [1:0] p2_op_r;
  reg [ADDR_W-1:0] p2_addr_r;
  reg [LANES-1:0] p2_we_r;

  // burst state
  reg burst_act_r;
  reg burst_wr_r;
  reg [ADDR_W-1:0] burst_base_r;
  reg [BURST_W-1:0] burst_cnt_r;

  reg [LANES-1:0] lane_mask_r;
  reg [CNT_W-1:0] wcount_r;
  reg [CNT_W-1:0] rcount_r;
  reg sel_last_r;

  wire run = ~clock_hold_n_i;
  wire selected = ~chip_select_low_a_i & ~chip_select_low_b_i & chip_select_high_i;
  wire load = ~advance_not_load_i;
  wire deselect = load & ~selected;

  // lane enables qualified by the software mask, one per lane
  wire [LANES-1:0] lane_we_w;
  genvar n;
  generate
    for (n = 0; n < LANES; n = n + 1) begin : lane_en
      // a set mask bit keeps its lane out of every write
      assign lane_we_w[n] = ~byte_lane_write_n_i[n] & ~lane_mask_r[n];
    end
  endgenerate

  reg [1:0] op_nxt;
  reg [ADDR_W-1:0] addr_nxt;
  reg [LANES-1:0] we_nxt;
  reg burst_act_nxt;
  reg burst_wr_nxt;
  reg [ADDR_W-1:0] burst_base_nxt;
  reg [BURST_W-1:0] burst_cnt_nxt;

  // decode of the access started or continued at this edge
  always @* begin
    op_nxt = `ZBSC_OP_IDLE;
    addr_nxt = burst_base_r;
    we_nxt = {LANES{1'b0}};
    burst_act_nxt = burst_act_r;
    burst_wr_nxt = burst_wr_r;
    burst_base_nxt = burst_base_r;
    burst_cnt_nxt = burst_cnt_r;
    if (deselect) begin
      // stops any burst, pending transfers in the pipe still complete
      burst_act_nxt = 1'b0;
    end else if (load) begin
      burst_act_nxt = 1'b1;
      burst_wr_nxt = ~read_not_write_i;
      burst_base_nxt = addr_i;
      burst_cnt_nxt = {BURST_W{1'b0}};
      addr_nxt = addr_i;
      if (read_not_write_i) begin
        op_nxt = `ZBSC_OP_READ;
      end else begin
        op_nxt = `ZBSC_OP_WRITE;
        we_nxt = lane_we_w;
      end
    end else if (burst_act_r) begin
      // advance: linear wrap within the burst group
      burst_cnt_nxt = burst_cnt_r + {{(BURST_W-1){1'b0}}, 1'b1};
      addr_nxt = {burst_base_r[ADDR_W-1:BURST_W], burst_base_r[BURST_W-1:0] + burst_cnt_nxt};
      if (burst_wr_r) begin
        op_nxt = `ZBSC_OP_WRITE;
        we_nxt = lane_we_w;
      end else begin
        op_nxt = `ZBSC_OP_READ;
      end
    end
  end

  // first stage: control of the access taken at this edge
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      p1_op_r <= `ZBSC_OP_IDLE;
      p1_addr_r <= {ADDR_W{1'b0}};
      p1_we_r <= {LANES{1'b0}};
    end else if (run) begin
      p1_op_r <= op_nxt;
      p1_addr_r <= addr_nxt;
      p1_we_r <= we_nxt;
    end
  end

  // second stage: the data slot of the access
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      p2_op_r <= `ZBSC_OP_IDLE;
      p2_addr_r <= {ADDR_W{1'b0}};
      p2_we_r <= {LANES{1'b0}};
    end else if (run) begin
      p2_op_r <= p1_op_r;
      p2_addr_r <= p1_addr_r;
      p2_we_r <= p1_we_r;
    end
  end

  // burst tracking, frozen with the pipe on held edges
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      burst_act_r <= 1'b0;
      burst_wr_r <= 1'b0;
      burst_base_r <= {ADDR_W{1'b0}};
      burst_cnt_r <= {BURST_W{1'b0}};
    end else if (run) begin
      burst_act_r <= burst_act_nxt;
      burst_wr_r <= burst_wr_nxt;
      burst_base_r <= burst_base_nxt;
      burst_cnt_r <= burst_cnt_nxt;
    end
  end

  // select seen at the last load, kept for status only
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_last_r <= 1'b0;
    end else if (run && load) begin
      sel_last_r <= selected;
    end
  end

  // read data with bypass from the write landing at the same edge
  wire wr_now = run && (p2_op_r == `ZBSC_OP_WRITE);
  wire rd_done = run && (p2_op_r == `ZBSC_OP_READ);
  wire bypass = wr_now && (p2_addr_r == p1_addr_r);
  wire [WORD_W-1:0] rd_merged;

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : lane
      // one array per lane keeps every lane write on a single driver
      reg [LANE_W-1:0] mem [0:DEPTH-1];
      wire [LANE_W-1:0] wr_slice = data_i[g*LANE_W +: LANE_W];
      wire [LANE_W-1:0] rd_slice = mem[p1_addr_r];
      wire lane_wr = wr_now && p2_we_r[g];
      wire lane_byp = bypass && p2_we_r[g];

      // a read right behind a same-address write sees the new lane data
      assign rd_merged[g*LANE_W +: LANE_W] = lane_byp ? wr_slice : rd_slice;

      always @(posedge sys_clk_i) begin
        if (lane_wr) begin
          mem[p2_addr_r] <= wr_slice;
        end
      end
    end
  endgenerate

  // read data launched at the first edge after the load, sampled at the second
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_o <= {WORD_W{1'b0}};
    end else if (run && p1_op_r == `ZBSC_OP_READ) begin
      data_o <= rd_merged;
    end
  end

  // writes and deselects float the bus for their data slot
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_oe_o <= 1'b0;
    end else if (run) begin
      data_oe_o <= (p1_op_r == `ZBSC_OP_READ);
    end
  end

  // register decode, shared by the write side
  wire hit_mask = (reg_addr_i == `ZBSC_REG_LANE_MASK);
  wire hit_wcnt = (reg_addr_i == `ZBSC_REG_WCOUNT);
  wire hit_rcnt = (reg_addr_i == `ZBSC_REG_RCOUNT);

  // software registers
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lane_mask_r <= `ZBSC_LANE_MASK_RST;
    end else if (reg_wr_i && hit_mask) begin
      lane_mask_r <= reg_wdata_i[LANES-1:0];
    end
  end

  // counters wrap; a slot done in the cycle of a clear wins over the clear
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wcount_r <= {CNT_W{1'b0}};
    end else if (wr_now) begin
      wcount_r <= wcount_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end else if (reg_wr_i && hit_wcnt) begin
      wcount_r <= {CNT_W{1'b0}};
    end
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rcount_r <= {CNT_W{1'b0}};
    end else if (rd_done) begin
      rcount_r <= rcount_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end else if (reg_wr_i && hit_rcnt) begin
      rcount_r <= {CNT_W{1'b0}};
    end
  end

  // status bits, upper bits read as zero
  wire [31:0] status_w;
  assign status_w[`ZBSC_ST_SEL] = sel_last_r;
  assign status_w[`ZBSC_ST_P1] = (p1_op_r != `ZBSC_OP_IDLE);
  assign status_w[`ZBSC_ST_P2] = (p2_op_r != `ZBSC_OP_IDLE);
  assign status_w[`ZBSC_ST_DRV] = data_oe_o;
  assign status_w[`ZBSC_ST_HOLD] = clock_hold_n_i;
  assign status_w[`ZBSC_ST_BURST] = burst_act_r;
  assign status_w[31:`ZBSC_ST_BURST+1] = {(31-`ZBSC_ST_BURST){1'b0}};

  reg [31:0] rd_nxt;
  always @* begin
    rd_nxt = 32'h00000000;
    case (reg_addr_i)
      `ZBSC_REG_LANE_MASK: begin
        rd_nxt[LANES-1:0] = lane_mask_r;
      end
      `ZBSC_REG_STATUS: begin
        rd_nxt = status_w;
      end
      `ZBSC_REG_WCOUNT: begin
        rd_nxt[CNT_W-1:0] = wcount_r;
      end
      `ZBSC_REG_RCOUNT: begin
        rd_nxt[CNT_W-1:0] = rcount_r;
      end
      default: begin
        rd_nxt = 32'h00000000;
      end
    endcase
  end

  // read data stands for one cycle only, zero otherwise

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_nxt;
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

endmodule

// >>> sim/zbsc_slice_checker.sv
// link-side assertions for the burst SRAM slice
`include "zbsc_defines.vh"
module zbsc_slice_checker (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic clock_hold_n_i,
  input wire logic chip_select_low_a_i,
  input wire logic chip_select_low_b_i,
  input wire logic chip_select_high_i,
  input wire logic advance_not_load_i,
  input wire logic read_not_write_i,
  input wire logic [`ZBSC_WORD_W-1:0] data_o,
  input wire logic data_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire run = !clock_hold_n_i;
  wire ld = run && !advance_not_load_i;
  wire sel = !chip_select_low_a_i && !chip_select_low_b_i && chip_select_high_i;
  wire rd = ld && sel && read_not_write_i;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  read_drive_a: assert property (rd ##1 run |=> data_oe_o)
    else $error("read not driven");
  write_float_a: assert property (ld && sel && !read_not_write_i ##1 run |=> !data_oe_o)
    else $error("write drove bus");
  desel_low_a: assert property (ld && !sel ##1 run |=> !data_oe_o)
    else $error("deselect drove bus");
  high_select_a: assert property (ld && !chip_select_high_i ##1 run |=> !data_oe_o)
    else $error("high select ignored");
  burst_stop_a: assert property (ld && !sel ##1 run && advance_not_load_i ##1 run
    |=> !data_oe_o) else $error("burst ran on");
  burst_read_a: assert property (rd ##1 run && advance_not_load_i ##1 run |=> data_oe_o)
    else $error("burst read lost");
  hold_freeze_a: assert property (clock_hold_n_i |=> $stable(data_o) && $stable(data_oe_o))
    else $error("held edge moved outputs");
  hold_delay_a: assert property (rd ##1 clock_hold_n_i ##1 run |=> data_oe_o)
    else $error("held read lost");
endmodule

bind zbsc_sram_slice zbsc_slice_checker u_chk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
  .clock_hold_n_i(clock_hold_n_i), .chip_select_low_a_i(chip_select_low_a_i),
  .chip_select_low_b_i(chip_select_low_b_i), .chip_select_high_i(chip_select_high_i),
  .advance_not_load_i(advance_not_load_i), .read_not_write_i(read_not_write_i),
  .data_o(data_o), .data_oe_o(data_oe_o));

// >>> sim/zbsc_ctrl_model.sv
// controller data phase: write word is driven one edge after its command, sampled at the next
module zbsc_ctrl_model (
  input wire logic clk_i,
  input wire logic hold_n_i,
  input wire logic rnw_i,
  input wire logic [35:0] wd_i,
  output logic [35:0] bus_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pend = 1'h0;
  logic [35:0] pdat = 36'h0;
  initial bus_o = 36'h0;
  // held edges freeze the data phase too
  always @(posedge clk_i) if (!hold_n_i) begin
    pend <= !rnw_i;
    pdat <= wd_i;
    // released bus flips, so a stale word never passes for fresh data
    bus_o <= pend ? pdat : ~bus_o;
  end
endmodule

// >>> sim/zbsc_sram_slice_test.sv
// self-checking bench for the burst SRAM byte-write / chip-select slice
`include "zbsc_defines.vh"
module zbsc_sram_slice_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] LW = 6'h04, LR = 6'h05, AW = 6'h06, AR = 6'h07;
  localparam logic [5:0] DA = 6'h14, DB = 6'h0D, ID = 6'h01, HD = 6'h25;
  localparam logic [1:0] I = `ZBSC_OP_IDLE, R = `ZBSC_OP_READ, W = `ZBSC_OP_WRITE;
  logic clk = 1'h0, rst_b = 1'h0, hold = 1'h0, cs_a = 1'h1, cs_b = 1'h1, cs_h = 1'h0;
  logic adv = 1'h0, rnw = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, oe;
  logic [3:0] bwn = 4'hF, msk = 4'h0, reg_addr = 4'h0;
  logic [16:0] addr = 17'h0;
  logic [35:0] wd = 36'h0, bus, dout;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [36:0] nx = 37'h0, e1 = 37'h0, e2 = 37'h0;
  logic [35:0] mem [int];
  int err_total = 0, num_checks = 0, cyc = 0;
  zbsc_sram_slice uut (.sys_clk_i(clk), .rst_b_i(rst_b), .clock_hold_n_i(hold),
    .chip_select_low_a_i(cs_a), .chip_select_low_b_i(cs_b), .chip_select_high_i(cs_h),
    .advance_not_load_i(adv), .read_not_write_i(rnw), .byte_lane_write_n_i(bwn),
    .addr_i(addr), .data_i(bus), .data_o(dout), .data_oe_o(oe), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));
  zbsc_ctrl_model u_ctl (.clk_i(clk), .hold_n_i(hold), .rnw_i(rnw), .wd_i(wd), .bus_o(bus));
  initial forever #2 clk = ~clk;
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // model word updated at issue; bypass makes that the order seen on reads
  task automatic op(input logic [5:0] c, input logic [3:0] b, input logic [16:0] a,
                    input logic [35:0] d, input logic [1:0] k);
    {hold, cs_a, cs_b, cs_h, adv, rnw} <= c;
    bwn <= b;
    addr <= a;
    wd <= d;
    if (k == W) for (int i = 0; i < 4; i++) if (!b[i] && !msk[i]) mem[a][9*i+:9] = d[9*i+:9];
    nx <= {k == R, (k == R) ? mem[a] : 36'h0};
    @(posedge clk);
  endtask
  task automatic rg(input logic w, input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    {reg_wr, reg_rd} <= {w, !w};
    @(posedge clk);
    {reg_wr, reg_rd} <= 2'h0;
    @(posedge clk);
    if (!w) chk({4'h0, reg_rdata}, {4'h0, d});
  endtask
  // expectations advance only on unheld edges, like the pipe itself
  always @(posedge clk) if (rst_b && !hold) begin
    if (e2[36]) chk(dout, e2[35:0]);
    chk({35'h0, oe}, {35'h0, e2[36]});
    e1 <= nx;
    e2 <= e1;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 500) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    op(LW, 4'h0, 17'h4, 36'h1_2345_6789, W);
    for (int j = 5; j < 8; j++) op(AW, 4'h0, 17'(j), {9{j[3:0]}}, W);
    op(LR, 4'h0, 17'h4, 36'h0, R);
    for (int j = 5; j < 8; j++) op(AR, 4'h0, 17'(j), 36'h0, R);
    for (int j = 0; j < 4; j++) begin
      op(LW, ~(4'h1 << j), 17'h4, {4{9'h1F0 + 9'(j)}}, W);
      op(LR, 4'hF, 17'h4, 36'h0, R);
    end
    op(LW, 4'h0, 17'h5, 36'hA_BCDE_F012, W);
    op(DA, 4'h0, 17'h5, 36'h0, I);
    op(AR, 4'h0, 17'h6, 36'h0, I);
    op(DB, 4'h0, 17'h5, 36'h0, I);
    op(ID, 4'h0, 17'h5, 36'h0, I);
    op(LR, 4'h0, 17'h5, 36'h0, R);
    op(HD, 4'h0, 17'h7, 36'h0, I);
    op(LW, 4'h0, 17'h6, 36'h5_5555_5555, W);
    op(HD, 4'h0, 17'h7, 36'h0, I);
    op(LR, 4'h0, 17'h6, 36'h0, R);
    op(LR, 4'h0, 17'h4, 36'h0, R);
    op(HD, 4'h0, 17'h7, 36'h0, I);
    repeat (3) op(ID, 4'h0, 17'h0, 36'h0, I);
    rg(1'h0, `ZBSC_REG_LANE_MASK, 32'h0);
    rg(1'h1, `ZBSC_REG_LANE_MASK, 32'h1);
    msk = 4'h1;
    rg(1'h0, `ZBSC_REG_LANE_MASK, 32'h1);
    rg(1'h0, 4'h2, 32'h0);
    op(LW, 4'h0, 17'h4, 36'hF_FFFF_FFFF, W);
    op(LR, 4'h0, 17'h4, 36'h0, R);
    repeat (3) op(ID, 4'h0, 17'h0, 36'h0, I);
    summarize();
  end
endmodule
